/* File: ppg_pkg.sv */
// Package for the peripheral privilege guard: register map, field layout, resets, carriers.
// Assumes a 32-bit APB register port and a simple processor-side access request bus.
package ppg_pkg;

  // Register byte offsets.
  localparam logic [11:0] OFF_IRQ_FLAGS   = 12'h00c;
  localparam logic [11:0] OFF_IRQ_SET     = 12'h010;
  localparam logic [11:0] OFF_IRQ_CLEAR   = 12'h014;
  localparam logic [11:0] OFF_IRQ_ENABLE  = 12'h018;
  localparam logic [11:0] OFF_CONTROL     = 12'h040;
  localparam logic [11:0] OFF_DESC0       = 12'h050;
  localparam logic [11:0] OFF_DESC1       = 12'h054;
  localparam logic [11:0] OFF_FAULT_STAT  = 12'h090;
  localparam logic [11:0] OFF_READ_CLEAR  = 12'h0a0;

  // Field positions and widths.
  localparam int FLAG_BIT    = 0;
  localparam int ENABLE_BIT  = 0;
  localparam int ID_WIDTH    = 7;
  localparam int NUM_PERIPH  = 36;
  localparam int DESC1_WIDTH = 4;
  localparam int GUARD_ID    = 24;

  // Reset values.
  localparam logic [31:0] RST_DESC0 = 32'h0000_0000;
  localparam logic [3:0]  RST_DESC1 = 4'h0;
  localparam logic [6:0]  RST_ID    = 7'h00;

  // One access from a bus master towards the peripheral space.
  typedef struct packed {
    logic       valid;
    logic       fromCpu;
    logic       privileged;
    logic       write;
    logic [6:0] faulting_peripheral_id;
  } ppg_access_t;

  // Configuration seen by the checker.
  typedef struct packed {
    logic                  enable;
    logic [NUM_PERIPH-1:0] descriptor;
  } ppg_config_t;

endpackage

/* File: ppg_checker.sv */
// Combinational privilege check of one access against the current guard configuration.
// Assumes the configuration comes straight from registers so changes act on the next access.
`timescale 1ns/10ps
`default_nettype none
module ppg_checker
  import ppg_pkg::*;
(
  // Access and configuration.
  input  wire ppg_access_t access,
  input  wire ppg_config_t cfg,
  // Result.
  output logic             blocked
);

  // An access is blocked only when enabled, from the processor, unprivileged and protected.
  always_comb begin
    blocked = 1'b0;
    if (cfg.enable && access.valid && access.fromCpu && !access.privileged) begin
      if (access.faulting_peripheral_id < 7'(NUM_PERIPH)) begin
        blocked = cfg.descriptor[access.faulting_peripheral_id[5:0]];
      end
    end
  end

endmodule
`default_nettype wire

/* File: ppg_fault_capture.sv */
// Fault flag and faulting identifier capture.
// Assumes one fault indication per cycle from the checker and decoded software strobes.
`timescale 1ns/10ps
`default_nettype none
module ppg_fault_capture
  import ppg_pkg::*;
(
  // Clock and reset.
  input  wire  logic       clk,
  input  wire  logic       sys_rst,
  // Events.
  input  wire  logic       faultHit,
  input  wire  logic [6:0] faultId,
  input  wire  logic       swSet,
  input  wire  logic       swClear,
  // State.
  output logic             faultFlag,
  output logic [6:0]       faultingPeripheralId
);

  logic       next_faultFlag;
  logic [6:0] next_faultingPeripheralId;

  // Set wins over clear; the identifier freezes while the flag is up.
  always_comb begin
    next_faultFlag            = faultFlag;
    next_faultingPeripheralId = faultingPeripheralId;
    if (swClear) begin
      next_faultFlag = 1'b0;
    end
    if (faultHit || swSet) begin
      next_faultFlag = 1'b1;
    end
    if (faultHit && !faultFlag) begin
      next_faultingPeripheralId = faultId;
    end
  end

  // Registers the flag and identifier.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      faultFlag            <= 1'b0;
      faultingPeripheralId <= RST_ID;
    end else begin
      faultFlag            <= next_faultFlag;
      faultingPeripheralId <= next_faultingPeripheralId;
    end
  end

endmodule
`default_nettype wire

/* File: ppg_guard.sv */
// Peripheral privilege guard top: APB register slave, access gate and interrupt.
// Assumes one processor-side access port per cycle and peripherals that answer reads
// combinationally on the downstream port in the same cycle.
`timescale 1ns/10ps
`default_nettype none

// Function
// - Guard disabled means no checking, no faults; reset disables it.
// - Enabled: descriptor bit 1 protects a peripheral, 0 permits all access.
// - Unprivileged access to protected peripheral sets flag and captures identifier.
// - Captured identifier holds while the fault flag is set.
// - Simultaneous faults capture exactly one identifier, no fixed priority needed.
// - Fault flag is read-only bit 0 at 0x00c, reset 0.
// - Writing 1 to bit 0 at 0x010 sets the flag.
// - Writing 1 at 0x014 clears; read-clear option makes reads clear too.
// - Enable bit 0 at 0x018 gates the flag onto the interrupt.
// - Descriptor at 0x050 holds 32 read-write protection bits, reset 0.
// - Blocked access reaches no peripheral; blocked reads return zero.
// - Fault status at 0x090 bits 6:0 hold the identifier.
// - Only processor accesses are checked; other masters always pass.
// - Configuration changes act on the very next access.
module ppg_guard
  import ppg_pkg::*;
(
  // Clock and reset.
  input  wire  logic        clk,
  input  wire  logic        sys_rst,
  // APB register slave.
  input  wire  logic        psel,
  input  wire  logic        penable,
  input  wire  logic        pwrite,
  input  wire  logic [11:0] paddr,
  input  wire  logic [31:0] pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  // Upstream access from a bus master.
  input  wire  ppg_access_t masterAccess,
  // Downstream peripheral port.
  input  wire  logic [31:0] periphRdata,
  output logic              periphValid,
  output logic [31:0]       masterRdata,
  output logic              accessBlocked,
  // Interrupt.
  output logic              irq
);

  // Configuration and status registers.
  logic        guardEnable;
  logic [31:0] descriptor0;
  logic [DESC1_WIDTH-1:0] descriptor1;
  logic        irqEnable;
  logic        readClearOn;
  logic        faultFlag;
  logic [6:0]  faultingPeripheralId;
  logic        next_guardEnable;
  logic [31:0] next_descriptor0;
  logic [DESC1_WIDTH-1:0] next_descriptor1;
  logic        next_irqEnable;
  logic        next_readClearOn;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic        next_irq;
  logic        next_periphValid;
  logic [31:0] next_masterRdata;
  logic        next_accessBlocked;
  ppg_config_t guardCfg;
  logic        blockNow;
  logic        apbSetup;
  logic        wrStrobe;
  logic        rdStrobe;
  logic        swSet;
  logic        swClear;

  // True for any offset that the register file answers.
  function automatic logic mapped(input logic [11:0] a);
    case (a)
      OFF_IRQ_FLAGS, OFF_IRQ_SET, OFF_IRQ_CLEAR, OFF_IRQ_ENABLE, OFF_CONTROL,
      OFF_DESC0, OFF_DESC1, OFF_FAULT_STAT, OFF_READ_CLEAR: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  // APB handshake: no wait states, answer registered in the setup cycle.
  assign apbSetup = psel && !penable;
  assign wrStrobe = apbSetup && pwrite && mapped(paddr);
  assign rdStrobe = apbSetup && !pwrite && mapped(paddr);
  assign swSet    = wrStrobe && (paddr == OFF_IRQ_SET) && pwdata[FLAG_BIT];
  assign swClear  = (wrStrobe && (paddr == OFF_IRQ_CLEAR) && pwdata[FLAG_BIT]) ||
                    (rdStrobe && (paddr == OFF_IRQ_CLEAR) && readClearOn);

  // Live configuration, read straight from registers with no pipeline.
  assign guardCfg.enable     = guardEnable;
  assign guardCfg.descriptor = {descriptor1, descriptor0};

  ppg_checker u_checker (
    .access  (masterAccess),
    .cfg     (guardCfg),
    .blocked (blockNow)
  );

  // One access port means at most one fault per cycle, so one identifier is caught.
  ppg_fault_capture u_capture (
    .clk                  (clk),
    .sys_rst              (sys_rst),
    .faultHit             (blockNow),
    .faultId              (masterAccess.faulting_peripheral_id),
    .swSet                (swSet),
    .swClear              (swClear),
    .faultFlag            (faultFlag),
    .faultingPeripheralId (faultingPeripheralId)
  );

  // Next values for configuration, APB answer, gate and interrupt.
  always_comb begin
    next_guardEnable = guardEnable;
    next_descriptor0 = descriptor0;
    next_descriptor1 = descriptor1;
    next_irqEnable   = irqEnable;
    next_readClearOn = readClearOn;
    next_prdata      = 32'h0000_0000;
    next_pready      = apbSetup;
    next_pslverr     = apbSetup && !mapped(paddr);
    if (wrStrobe) begin
      unique case (paddr)
        OFF_IRQ_ENABLE: next_irqEnable   = pwdata[FLAG_BIT];
        OFF_CONTROL:    next_guardEnable = pwdata[ENABLE_BIT];
        OFF_DESC0:      next_descriptor0 = pwdata;
        OFF_DESC1:      next_descriptor1 = pwdata[DESC1_WIDTH-1:0];
        OFF_READ_CLEAR: next_readClearOn = pwdata[0];
        default: begin
        end
      endcase
    end
    if (rdStrobe) begin
      unique case (paddr)
        OFF_IRQ_FLAGS:  next_prdata[FLAG_BIT] = faultFlag;
        OFF_IRQ_CLEAR:  next_prdata[FLAG_BIT] = readClearOn ? faultFlag : 1'b0;
        OFF_IRQ_ENABLE: next_prdata[FLAG_BIT] = irqEnable;
        OFF_CONTROL:    next_prdata[ENABLE_BIT] = guardEnable;
        OFF_DESC0:      next_prdata = descriptor0;
        OFF_DESC1:      next_prdata[DESC1_WIDTH-1:0] = descriptor1;
        OFF_FAULT_STAT: next_prdata[ID_WIDTH-1:0] = faultingPeripheralId;
        OFF_READ_CLEAR: next_prdata[0] = readClearOn;
        default: begin
        end
      endcase
    end
    // A blocked access never reaches the peripheral and reads back zero.
    next_periphValid   = masterAccess.valid && !blockNow;
    next_masterRdata   = blockNow ? 32'h0000_0000 : periphRdata;
    next_accessBlocked = blockNow;
    next_irq           = faultFlag && irqEnable;
  end

  // Registers the configuration state and every output; the fault flag and identifier are registered in u_capture.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      guardEnable   <= 1'b0;
      descriptor0   <= RST_DESC0;
      descriptor1   <= RST_DESC1;
      irqEnable     <= 1'b0;
      readClearOn   <= 1'b0;
      prdata        <= 32'h0000_0000;
      pready        <= 1'b0;
      pslverr       <= 1'b0;
      periphValid   <= 1'b0;
      masterRdata   <= 32'h0000_0000;
      accessBlocked <= 1'b0;
      irq           <= 1'b0;
    end else begin
      guardEnable   <= next_guardEnable;
      descriptor0   <= next_descriptor0;
      descriptor1   <= next_descriptor1;
      irqEnable     <= next_irqEnable;
      readClearOn   <= next_readClearOn;
      prdata        <= next_prdata;
      pready        <= next_pready;
      pslverr       <= next_pslverr;
      periphValid   <= next_periphValid;
      masterRdata   <= next_masterRdata;
      accessBlocked <= next_accessBlocked;
      irq           <= next_irq;
    end
  end

  // Protected unprivileged processor access while enabled raises the flag next cycle.
  property p_fault_sets;
    @(posedge clk) disable iff (sys_rst) blockNow |=> faultFlag;
  endproperty
  a_fault_sets: assert property (p_fault_sets) else $error("fault did not set flag");

  // Disabled guard never blocks.
  property p_disabled_passes;
    @(posedge clk) disable iff (sys_rst) !guardEnable |-> !blockNow;
  endproperty
  a_disabled_passes: assert property (p_disabled_passes) else $error("blocked while off");

  // Non-processor masters always pass.
  property p_other_master;
    @(posedge clk) disable iff (sys_rst) !masterAccess.fromCpu |-> !blockNow;
  endproperty
  a_other_master: assert property (p_other_master) else $error("other master blocked");

  // Identifier stays put while the flag stays set.
  property p_id_hold;
    @(posedge clk) disable iff (sys_rst)
      faultFlag && $past(faultFlag) |-> $stable(faultingPeripheralId);
  endproperty
  a_id_hold: assert property (p_id_hold) else $error("identifier changed");

  // Blocked access yields zero data and no downstream strobe.
  property p_block_zero;
    @(posedge clk) disable iff (sys_rst)
      blockNow |=> (masterRdata == 32'h0000_0000) && !periphValid;
  endproperty
  a_block_zero: assert property (p_block_zero) else $error("blocked access leaked");

  // Interrupt follows flag and enable one cycle later.
  property p_irq;
    @(posedge clk) disable iff (sys_rst) ##1 irq == $past(faultFlag && irqEnable);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt mismatch");

  // A set write raises the flag next cycle.
  property p_sw_set;
    @(posedge clk) disable iff (sys_rst) swSet |=> faultFlag;
  endproperty
  a_sw_set: assert property (p_sw_set) else $error("set write ignored");

  // A clear with no competing event drops the flag.
  property p_sw_clear;
    @(posedge clk) disable iff (sys_rst) swClear && !swSet && !blockNow |=> !faultFlag;
  endproperty
  a_sw_clear: assert property (p_sw_clear) else $error("clear ignored");

  // Enabled guard blocks an unprivileged processor access to a peripheral protected in descriptor0 (identifiers below 32).
  property p_enabled_blocks;
    @(posedge clk) disable iff (sys_rst)
      guardEnable && masterAccess.valid && masterAccess.fromCpu && !masterAccess.privileged &&
      masterAccess.faulting_peripheral_id < 7'd32 && descriptor0[masterAccess.faulting_peripheral_id[4:0]] |-> blockNow;
  endproperty
  a_enabled_blocks: assert property (p_enabled_blocks) else $error("protection missed");

  // A passed access strobes the peripheral on the next cycle.
  property p_pass_strobe;
    @(posedge clk) disable iff (sys_rst) masterAccess.valid && !blockNow |=> periphValid;
  endproperty
  a_pass_strobe: assert property (p_pass_strobe) else $error("passed access dropped");

  // A passed access hands the peripheral data back unchanged.
  property p_pass_data;
    @(posedge clk) disable iff (sys_rst)
      masterAccess.valid && !blockNow |=> masterRdata == $past(periphRdata);
  endproperty
  a_pass_data: assert property (p_pass_data) else $error("passed data altered");

  // A blocked access is reported on the next cycle.
  property p_block_report;
    @(posedge clk) disable iff (sys_rst) blockNow |=> accessBlocked;
  endproperty
  a_block_report: assert property (p_block_report) else $error("block not reported");

  // The first fault while the flag is clear captures the accessed identifier.
  property p_id_capture;
    @(posedge clk) disable iff (sys_rst)
      blockNow && !faultFlag |=> faultingPeripheralId == $past(masterAccess.faulting_peripheral_id);
  endproperty
  a_id_capture: assert property (p_id_capture) else $error("identifier not captured");

  // A write to the flag register leaves the flag alone.
  property p_flag_ro;
    @(posedge clk) disable iff (sys_rst)
      wrStrobe && (paddr == OFF_IRQ_FLAGS) && !blockNow |=> faultFlag == $past(faultFlag);
  endproperty
  a_flag_ro: assert property (p_flag_ro) else $error("flag written");

  // A control write reaches the guard enable on the next cycle.
  property p_ctrl_write;
    @(posedge clk) disable iff (sys_rst)
      wrStrobe && (paddr == OFF_CONTROL) |=> guardEnable == $past(pwdata[ENABLE_BIT]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

  // A write to descriptor0 at 0x050 lands whole.
  property p_desc_write;
    @(posedge clk) disable iff (sys_rst)
      wrStrobe && (paddr == OFF_DESC0) |=> descriptor0 == $past(pwdata);
  endproperty
  a_desc_write: assert property (p_desc_write) else $error("descriptor write lost");

  // A fault status read returns the captured identifier.
  property p_status_read;
    @(posedge clk) disable iff (sys_rst)
      rdStrobe && (paddr == OFF_FAULT_STAT) |=> prdata == {25'h0, $past(faultingPeripheralId)};
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong");

  // Main scenarios.
  c_fault: cover property (@(posedge clk) disable iff (sys_rst) blockNow ##1 irq);
  c_clear: cover property (@(posedge clk) disable iff (sys_rst) faultFlag ##1 swClear ##1 !faultFlag);
  c_rdclr: cover property (@(posedge clk) disable iff (sys_rst) readClearOn && rdStrobe && faultFlag);
  c_other: cover property (@(posedge clk) disable iff (sys_rst)
    guardEnable && masterAccess.valid && !masterAccess.fromCpu);

endmodule
`default_nettype wire

/* File: ppg_cpu_model.sv */
// Processor-side partner of the guard: issues one access at a time and plays the peripherals.
// Assumes the guard answers one cycle after the access edge on its registered outputs.
`timescale 1ns/10ps
`default_nettype none
module ppg_cpu_model
  import ppg_pkg::*;
(
  // Clock.
  input  wire  logic        clk,
  // Access towards the guard.
  output var ppg_access_t   acc,
  output logic [31:0]       periphRdata,
  // Answer from the guard.
  input  wire  logic        accessBlocked,
  input  wire  logic        periphValid,
  input  wire  logic [31:0] masterRdata
);
  // Peripherals answer with a pattern holding their id; an idle bus shows the inverse.
  assign periphRdata = acc.valid ? {16'hbeef, 9'h000, acc.faulting_peripheral_id}
                                 : ~{16'hbeef, 9'h000, acc.faulting_peripheral_id};

  initial acc = '0;

  // Drives one access for a single cycle and collects the answer one cycle later.
  task automatic issue(input logic cpu, priv, wrt, input logic [6:0] id,
                       output logic blk, vld, output logic [31:0] data);
    acc <= {1'b1, cpu, priv, wrt, id};
    @(posedge clk);
    acc.valid <= 1'b0;
    @(negedge clk);
    blk = accessBlocked;
    vld = periphValid;
    data = masterRdata;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* File: test_peripheral_privilege_guard.sv */
// Self-checking bench for the guard: APB register tasks plus processor accesses.
// Assumes the guard package and the processor partner model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module test_peripheral_privilege_guard
  import ppg_pkg::*;
;
  logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic        periphValid, accessBlocked, irq, er, bl, pv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, periphRdata, masterRdata, rd;
  ppg_access_t masterAccess;
  int          failures, comparisons;
  logic [11:0] resetOffs [6] = '{OFF_IRQ_FLAGS, OFF_IRQ_ENABLE, OFF_CONTROL, OFF_DESC0,
                                 OFF_DESC1, OFF_FAULT_STAT};

  ppg_guard ppg_guard_i (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .masterAccess(masterAccess), .periphRdata(periphRdata),
    .periphValid(periphValid), .masterRdata(masterRdata), .accessBlocked(accessBlocked),
    .irq(irq));

  ppg_cpu_model ppg_cpu_model_i (.clk(clk), .acc(masterAccess), .periphRdata(periphRdata),
    .accessBlocked(accessBlocked), .periphValid(periphValid), .masterRdata(masterRdata));

  // Clock at 50 MHz.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Counts a comparison and reports a mismatch.
  task automatic check(input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer: setup, then access until pready is seen high at a rising edge.
  // Data and error are taken at that edge; one idle cycle follows the release.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  // Checks the interrupt level in mid-cycle.
  task automatic irqchk(input logic exp);
    @(negedge clk);
    check({31'h0, irq}, {31'h0, exp});
    @(posedge clk);
  endtask

  // One processor-side access with the expected pass or block outcome.
  task automatic acc(input logic cpu, priv, wrt, input logic [6:0] id, input logic blk);
    ppg_cpu_model_i.issue(cpu, priv, wrt, id, bl, pv, rd);
    check({30'h0, bl, pv}, blk ? 32'h2 : 32'h1);
    if (!wrt)
      check(rd, blk ? 32'h0 : {16'hbeef, 9'h000, id});
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Watchdog well beyond the length of the sequence.
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    $display("FAIL t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
    results();
  end

  // Main sequence.
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    failures = 0;
    comparisons = 0;
    sys_rst = 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    foreach (resetOffs[i])
      rdchk(resetOffs[i], 32'h0);
    rdchk(12'h020, 32'h0);
    check({31'h0, er}, 32'h1);
    $display("test reset values done");
    apb(1'b1, OFF_DESC0, 32'h0100_00a0);
    rdchk(OFF_DESC0, 32'h0100_00a0);
    acc(1'b1, 1'b0, 1'b0, 7'd5, 1'b0);
    rdchk(OFF_IRQ_FLAGS, 32'h0);
    $display("test disabled guard done");
    apb(1'b1, OFF_CONTROL, 32'h1);
    rdchk(OFF_CONTROL, 32'h1);
    acc(1'b1, 1'b0, 1'b0, 7'd6, 1'b0);
    acc(1'b1, 1'b1, 1'b0, 7'd5, 1'b0);
    acc(1'b0, 1'b0, 1'b0, 7'd5, 1'b0);
    acc(1'b1, 1'b0, 1'b1, 7'd5, 1'b1);
    rdchk(OFF_IRQ_FLAGS, 32'h1);
    rdchk(OFF_FAULT_STAT, 32'h5);
    acc(1'b1, 1'b0, 1'b0, 7'd7, 1'b1);
    rdchk(OFF_FAULT_STAT, 32'h5);
    irqchk(1'b0);
    apb(1'b1, OFF_DESC0, 32'h0);
    acc(1'b1, 1'b0, 1'b0, 7'd7, 1'b0);
    $display("test enabled guard done");
    apb(1'b1, OFF_IRQ_ENABLE, 32'h1);
    rdchk(OFF_IRQ_ENABLE, 32'h1);
    irqchk(1'b1);
    apb(1'b1, OFF_IRQ_CLEAR, 32'h0);
    rdchk(OFF_IRQ_FLAGS, 32'h1);
    apb(1'b1, OFF_IRQ_CLEAR, 32'h1);
    rdchk(OFF_IRQ_FLAGS, 32'h0);
    irqchk(1'b0);
    apb(1'b1, OFF_IRQ_FLAGS, 32'h1);
    rdchk(OFF_IRQ_FLAGS, 32'h0);
    apb(1'b1, OFF_IRQ_SET, 32'h0);
    rdchk(OFF_IRQ_FLAGS, 32'h0);
    apb(1'b1, OFF_IRQ_SET, 32'h1);
    rdchk(OFF_IRQ_FLAGS, 32'h1);
    rdchk(OFF_IRQ_CLEAR, 32'h0);
    irqchk(1'b1);
    $display("test flags done");
    apb(1'b1, OFF_READ_CLEAR, 32'h1);
    rdchk(OFF_READ_CLEAR, 32'h1);
    rdchk(OFF_IRQ_CLEAR, 32'h1);
    rdchk(OFF_IRQ_FLAGS, 32'h0);
    apb(1'b1, OFF_DESC0, 32'h0000_0200);
    acc(1'b1, 1'b0, 1'b0, 7'd9, 1'b1);
    rdchk(OFF_FAULT_STAT, 32'h9);
    apb(1'b1, OFF_DESC1, 32'h1);
    acc(1'b1, 1'b0, 1'b0, 7'd32, 1'b1);
    rdchk(OFF_FAULT_STAT, 32'h9);
    apb(1'b1, OFF_CONTROL, 32'h0);
    acc(1'b1, 1'b0, 1'b0, 7'd9, 1'b0);
    $display("test read clear and recapture done");
    results();
  end
endmodule
`default_nettype wire
